// ---- core/mouse_cmd_map.vh ----
// Command codes, reply codes, defaults and timing counts for the interpreter
`ifndef MOUSE_CMD_MAP_VH
`define MOUSE_CMD_MAP_VH

// Standard commands
`define CMD_RESET      8'hFF
`define CMD_RESEND     8'hFE
`define CMD_DEFAULT    8'hF6
`define CMD_DISABLE    8'hF5
`define CMD_ENABLE     8'hF4
`define CMD_SET_RATE   8'hF3
`define CMD_DEV_TYPE   8'hF2
`define CMD_REMOTE     8'hF0
`define CMD_WRAP       8'hEE
`define CMD_UNWRAP     8'hEC
`define CMD_READ_DATA  8'hEB
`define CMD_STREAM     8'hEA
`define CMD_STATUS     8'hE9
`define CMD_SET_RES    8'hE8
`define CMD_SCALE_2    8'hE7
`define CMD_SCALE_1    8'hE6
`define CMD_SEC_ID     8'hE1
`define CMD_EXT        8'hE2

// Extended sub-commands
`define EXT_PWR_DOWN   8'h44
`define EXT_RESTART    8'h7F
`define EXT_VERSION    8'h46
`define EXT_CALIB      8'h51
`define EXT_QUICK_MAX  8'h3F
`define EXT_RD_REG     8'h80
`define EXT_WR_REG     8'h81
`define EXT_RD_BLOCK   8'h82
`define EXT_GET_PAGE   8'h83
`define EXT_SET_PAGE   8'h84
`define EXT_TOGGLE     8'h47

// Replies
`define RSP_ACK        8'hFA
`define RSP_RESEND     8'hFE
`define RSP_ERROR      8'hFC
`define RSP_POST_OK    8'hAA
`define RSP_ID         8'h00

// Defaults and limits
`define DEF_RATE       8'h64
`define DEF_RES        8'h02
`define MAX_RES        8'h03
`define BLOCK_LEN      3'd6

// Status byte fields
`define ST_SCALE_BIT   4
`define ST_ENABLE_BIT  5
`define ST_REMOTE_BIT  6

// Timing: clock rate in kHz and calibration time in ms
`define CLK_KHZ        20000
`define CALIB_MS       50
`define CALIB_CYCLES   (`CALIB_MS * `CLK_KHZ)

`endif

// ---- core/byte_sender.v ----
// Response byte queue feeding the byte transmitter, one byte at a time
`timescale 1ns/10ps
module byte_sender (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // Load side
  input  wire       load,
  input  wire [2:0] load_len,
  input  wire [63:0] load_bytes,
  // Transmitter side
  output wire       tx_valid,
  output wire [7:0] tx_data,
  input  wire       tx_ready,
  output wire       busy
);

  // ===========================================================
  // Shift register of pending bytes, first byte in low lane
  reg [63:0] bytes_ff;
  reg [2:0]  left_ff;

  // A new load replaces anything still pending; only motion reports wait for idle, command replies load at once
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bytes_ff <= 64'h0000_0000_0000_0000;
      left_ff  <= 3'd0;
    end else if (load) begin
      bytes_ff <= load_bytes;
      left_ff  <= load_len;
    end else if (tx_valid && tx_ready) begin
      bytes_ff <= {8'h00, bytes_ff[63:8]};
      left_ff  <= left_ff - 3'd1;
    end
  end

  assign tx_valid = (left_ff != 3'd0);
  assign tx_data  = bytes_ff[7:0];
  assign busy     = tx_valid;

endmodule

// ---- core/mouse_cmd_handler.v ----
// Mouse command interpreter: decodes host bytes and queues reply packets
`timescale 1ns/10ps
`include "mouse_cmd_map.vh"
module mouse_cmd_handler #(
  parameter [7:0]  VERSION_NUM = 8'h01,  // Arbitrary value
  parameter [7:0]  REVISION_NUM = 8'h00, // Arbitrary value
  parameter [15:0] SEC_ID = 16'h1234,    // Arbitrary value
  parameter        CALIB_CYCLES = `CALIB_CYCLES
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Host byte receiver
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  // Host byte transmitter
  output wire        tx_valid,
  output wire [7:0]  tx_data,
  input  wire        tx_ready,
  // Motion source
  input  wire [2:0]  buttons,
  input  wire [8:0]  move_x,
  input  wire [8:0]  move_y,
  input  wire        motion_event,
  // Motion and sensor control
  output reg         clear_motion_ff,
  output reg         calib_busy_ff,
  output reg         powered_down_ff,
  output wire        reporting_on,
  // Register page access
  output reg         reg_we_ff,
  output reg  [7:0]  reg_addr_ff,
  output reg  [7:0]  reg_wdata_ff,
  output reg  [7:0]  reg_page_ff,
  input  wire [7:0]  reg_rdata
);

  // ===========================================================
  // Parser states
  localparam [3:0] S_IDLE     = 4'd0;
  localparam [3:0] S_RATE     = 4'd1;
  localparam [3:0] S_RES      = 4'd2;
  localparam [3:0] S_EXT      = 4'd3;
  localparam [3:0] S_EXT_ADDR = 4'd4;
  localparam [3:0] S_EXT_DATA = 4'd5;
  localparam [3:0] S_RD_WAIT  = 4'd6;
  localparam [3:0] S_CALIB    = 4'd7;
  localparam [3:0] S_DEAD     = 4'd8;

  // ===========================================================
  // Mode and setting registers
  reg        remote_ff;
  reg        enable_ff;
  reg        wrap_ff;
  reg        wrap_remote_ff;
  reg        scale_ff;
  reg [7:0]  rate_ff;
  reg [7:0]  res_ff;
  reg        bad_ff;
  reg [3:0]  state_ff;
  reg [7:0]  ext_op_ff;
  reg [2:0]  blk_cnt_ff;
  reg [63:0] blk_ff;
  reg [24:0] calib_cnt_ff;
  reg [63:0] last_ff;
  reg [2:0]  last_len_ff;

  // Outgoing packet request
  reg        load;
  reg [2:0]  load_len;
  reg [63:0] load_bytes;
  wire       busy;

  assign reporting_on = enable_ff && !remote_ff && !wrap_ff;

  // Motion packet from current sample
  function [23:0] motion_pkt;
    input [2:0] b;
    input [8:0] x;
    input [8:0] y;
    begin
      motion_pkt = {y[7:0], x[7:0], 2'b00, y[8], x[8], 1'b1, b};
    end
  endfunction

  // Valid sample-rate parameter values
  function rate_ok;
    input [7:0] v;
    begin
      rate_ok = (v == 8'h0A) || (v == 8'h14) || (v == 8'h28) ||
                (v == 8'h3C) || (v == 8'h50) || (v == 8'h64) ||
                (v == 8'hC8);
    end
  endfunction

  wire [23:0] mpkt = motion_pkt(buttons, move_x, move_y);
  wire [7:0]  status1 = {1'b0, remote_ff, enable_ff, scale_ff, 1'b0,
                         buttons[0], buttons[2], buttons[1]};

  // ===========================================================
  // Main interpreter
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remote_ff       <= 1'b0;
      enable_ff       <= 1'b0;
      wrap_ff         <= 1'b0;
      wrap_remote_ff  <= 1'b0;
      scale_ff        <= 1'b0;
      rate_ff         <= `DEF_RATE;
      res_ff          <= `DEF_RES;
      bad_ff          <= 1'b0;
      state_ff        <= S_IDLE;
      ext_op_ff       <= 8'h00;
      blk_cnt_ff      <= 3'd0;
      blk_ff          <= 64'h0000_0000_0000_0000;
      calib_cnt_ff    <= 25'd0;
      last_ff         <= 64'h0000_0000_0000_0000;
      last_len_ff     <= 3'd0;
      clear_motion_ff <= 1'b0;
      calib_busy_ff   <= 1'b0;
      powered_down_ff <= 1'b0;
      reg_we_ff       <= 1'b0;
      reg_addr_ff     <= 8'h00;
      reg_wdata_ff    <= 8'h00;
      reg_page_ff     <= 8'h00;
      load            <= 1'b0;
      load_len        <= 3'd0;
      load_bytes      <= 64'h0000_0000_0000_0000;
    end else begin
      load            <= 1'b0;
      reg_we_ff       <= 1'b0;
      clear_motion_ff <= 1'b0;
      case (state_ff)
        S_DEAD: begin
          // Only the hardware reset leaves this state
          powered_down_ff <= 1'b1;
        end
        S_CALIB: begin
          // Calibration runs after the acknowledge has gone
          if (!busy && !load) begin
            calib_busy_ff <= 1'b1;
            if (calib_cnt_ff == CALIB_CYCLES - 1) begin
              calib_busy_ff <= 1'b0;
              calib_cnt_ff  <= 25'd0;
              state_ff      <= S_IDLE;
            end else begin
              calib_cnt_ff <= calib_cnt_ff + 25'd1;
            end
          end
        end
        S_RD_WAIT: begin
          // Register reads take one cycle; block reads gather six
          blk_ff     <= {reg_rdata, blk_ff[63:8]};
          blk_cnt_ff <= blk_cnt_ff - 3'd1;
          reg_addr_ff <= reg_addr_ff + 8'h01;
          if (blk_cnt_ff == 3'd1) begin
            state_ff <= S_IDLE;
            load     <= 1'b1;
            if (ext_op_ff == `EXT_RD_BLOCK) begin
              load_len   <= 3'd7;
              load_bytes <= {8'h00, reg_rdata, blk_ff[63:24], `RSP_ACK};
            end else begin
              load_len   <= 3'd2;
              load_bytes <= {48'h0, reg_rdata, `RSP_ACK};
            end
          end
        end
        default: begin
          // Motion reports go out only when no command is in progress
          if (!rx_valid && !busy && !load && state_ff == S_IDLE &&
              reporting_on && motion_event) begin
            load            <= 1'b1;
            load_len        <= 3'd3;
            load_bytes      <= {40'h0, mpkt};
            last_ff         <= {40'h0, mpkt};
            last_len_ff     <= 3'd3;
            clear_motion_ff <= 1'b1;
          end
          if (rx_valid) begin
            load <= 1'b1;
            // Default reply is a lone acknowledge
            load_len   <= 3'd1;
            load_bytes <= {56'h0, `RSP_ACK};
            bad_ff     <= 1'b0;
            if (wrap_ff && rx_data != `CMD_RESET &&
                rx_data != `CMD_UNWRAP) begin
              load_bytes <= {56'h0, rx_data};
            end else if (state_ff == S_RATE) begin
              state_ff <= S_IDLE;
              if (rate_ok(rx_data)) rate_ff <= rx_data;
              else begin
                load_bytes <= {56'h0, bad_ff ? `RSP_ERROR : `RSP_RESEND};
                bad_ff     <= 1'b1;
              end
            end else if (state_ff == S_RES) begin
              state_ff <= S_IDLE;
              if (rx_data <= `MAX_RES) res_ff <= rx_data;
              else begin
                load_bytes <= {56'h0, bad_ff ? `RSP_ERROR : `RSP_RESEND};
                bad_ff     <= 1'b1;
              end
            end else if (state_ff == S_EXT) begin
              // Extended sub-command byte
              ext_op_ff <= rx_data;
              state_ff  <= S_IDLE;
              if (rx_data <= `EXT_QUICK_MAX) begin
                load        <= 1'b0;
                reg_addr_ff <= rx_data;
                blk_cnt_ff  <= 3'd1;
                state_ff    <= S_RD_WAIT;
              end else if (rx_data == `EXT_PWR_DOWN) begin
                load     <= 1'b0;
                state_ff <= S_DEAD;
              end else if (rx_data == `EXT_RESTART) begin
                // Power-on defaults, then post message
                load_len   <= 3'd3;
                load_bytes <= {40'h0, `RSP_ID, `RSP_POST_OK, `RSP_ACK};
                remote_ff  <= 1'b0;
                enable_ff  <= 1'b0;
                wrap_ff    <= 1'b0;
                scale_ff   <= 1'b0;
                rate_ff    <= `DEF_RATE;
                res_ff     <= `DEF_RES;
                reg_page_ff <= 8'h00;
                clear_motion_ff <= 1'b1;
              end else if (rx_data == `EXT_VERSION) begin
                load_len   <= 3'd3;
                load_bytes <= {40'h0, REVISION_NUM, VERSION_NUM, `RSP_ACK};
              end else if (rx_data == `EXT_CALIB) begin
                state_ff <= S_CALIB;
              end else if (rx_data == `EXT_GET_PAGE) begin
                load_len   <= 3'd2;
                load_bytes <= {48'h0, reg_page_ff, `RSP_ACK};
              end else if (rx_data == `EXT_RD_REG ||
                           rx_data == `EXT_RD_BLOCK ||
                           rx_data == `EXT_WR_REG ||
                           rx_data == `EXT_TOGGLE ||
                           rx_data == `EXT_SET_PAGE) begin
                load     <= 1'b0;
                state_ff <= S_EXT_ADDR;
              end else begin
                load_bytes <= {56'h0, bad_ff ? `RSP_ERROR : `RSP_RESEND};
                bad_ff     <= 1'b1;
              end
            end else if (state_ff == S_EXT_ADDR) begin
              reg_addr_ff <= rx_data;
              state_ff    <= S_IDLE;
              if (ext_op_ff == `EXT_SET_PAGE) begin
                reg_page_ff <= rx_data;
              end else if (ext_op_ff == `EXT_RD_REG) begin
                load       <= 1'b0;
                blk_cnt_ff <= 3'd1;
                state_ff   <= S_RD_WAIT;
              end else if (ext_op_ff == `EXT_RD_BLOCK) begin
                load       <= 1'b0;
                blk_cnt_ff <= `BLOCK_LEN;
                state_ff   <= S_RD_WAIT;
              end else begin
                load     <= 1'b0;
                state_ff <= S_EXT_DATA;
              end
            end else if (state_ff == S_EXT_DATA) begin
              // Write or XOR the data byte into the register
              state_ff  <= S_IDLE;
              reg_we_ff <= 1'b1;
              reg_wdata_ff <= (ext_op_ff == `EXT_TOGGLE) ?
                              (reg_rdata ^ rx_data) : rx_data;
            end else begin
              case (rx_data)
                `CMD_RESET, `CMD_DEFAULT: begin
                  // Defaults, page zero, motion cleared
                  remote_ff   <= 1'b0;
                  enable_ff   <= 1'b0;
                  wrap_ff     <= 1'b0;
                  scale_ff    <= 1'b0;
                  rate_ff     <= `DEF_RATE;
                  res_ff      <= `DEF_RES;
                  reg_page_ff <= 8'h00;
                  clear_motion_ff <= 1'b1;
                  if (rx_data == `CMD_RESET) begin
                    load_len   <= 3'd3;
                    load_bytes <= {40'h0, `RSP_ID, `RSP_POST_OK, `RSP_ACK};
                  end
                end
                `CMD_RESEND: begin
                  // Repeat last packet, or a lone FA
                  if (last_len_ff != 3'd0) begin
                    load_len   <= last_len_ff;
                    load_bytes <= last_ff;
                  end
                end
                `CMD_DISABLE: enable_ff <= 1'b0;
                `CMD_ENABLE:  enable_ff <= 1'b1;
                `CMD_SET_RATE: state_ff <= S_RATE;
                `CMD_SET_RES:  state_ff <= S_RES;
                `CMD_SCALE_2:  scale_ff <= 1'b1;
                `CMD_SCALE_1:  scale_ff <= 1'b0;
                `CMD_DEV_TYPE: begin
                  load_len   <= 3'd2;
                  load_bytes <= {48'h0, `RSP_ID, `RSP_ACK};
                end
                `CMD_SEC_ID: begin
                  load_len   <= 3'd3;
                  load_bytes <= {40'h0, SEC_ID[15:8], SEC_ID[7:0],
                                 `RSP_ACK};
                end
                `CMD_REMOTE: remote_ff <= 1'b1;
                `CMD_STREAM: remote_ff <= 1'b0;
                `CMD_WRAP: begin
                  wrap_ff        <= 1'b1;
                  wrap_remote_ff <= remote_ff;
                end
                `CMD_UNWRAP: begin
                  if (wrap_ff) begin
                    wrap_ff   <= 1'b0;
                    remote_ff <= wrap_remote_ff;
                    if (!wrap_remote_ff) enable_ff <= 1'b0;
                  end
                end
                `CMD_READ_DATA: begin
                  load_len        <= 3'd4;
                  load_bytes      <= {32'h0, mpkt, `RSP_ACK};
                  clear_motion_ff <= 1'b1;
                end
                `CMD_STATUS: begin
                  load_len   <= 3'd4;
                  load_bytes <= {32'h0, rate_ff, res_ff, status1,
                                 `RSP_ACK};
                end
                `CMD_EXT: state_ff <= S_EXT;
                default: begin
                  load_bytes <= {56'h0, bad_ff ? `RSP_ERROR : `RSP_RESEND};
                  bad_ff     <= 1'b1;
                end
              endcase
            end
          end
        end
      endcase
      // Remember the last packet sent, ack stripped unless alone
      if (load && !(state_ff == S_IDLE && rx_valid)) begin
        if (load_bytes != last_ff || load_len != last_len_ff) begin
          if (load_len == 3'd1) begin
            last_ff     <= load_bytes;
            last_len_ff <= 3'd1;
          end else if (load_bytes[7:0] == `RSP_ACK) begin
            last_ff     <= {8'h00, load_bytes[63:8]};
            last_len_ff <= load_len - 3'd1;
          end else begin
            last_ff     <= load_bytes;
            last_len_ff <= load_len;
          end
        end
      end
    end
  end

  // ===========================================================
  // Reply queue towards the byte transmitter
  byte_sender u_sender (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .load       (load),
    .load_len   (load_len),
    .load_bytes (load_bytes),
    .tx_valid   (tx_valid),
    .tx_data    (tx_data),
    .tx_ready   (tx_ready),
    .busy       (busy)
  );

endmodule

// ---- tb/mouse_cmd_props.sv ----
// Port-level checker for the mouse command interpreter
`timescale 1ns/10ps
module mouse_cmd_props #(
  parameter CALIB_CYCLES = 20
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Host byte traffic
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  // Control outputs
  input wire logic       clear_motion_ff,
  input wire logic       calib_busy_ff,
  input wire logic       powered_down_ff,
  input wire logic       reporting_on,
  input wire logic       reg_we_ff,
  input wire logic [7:0] reg_page_ff
);
  // ==========================================================
  // Helper logic
  // Counts busy cycles so a stuck calibration shows up
  int busy_cnt_ff;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= calib_busy_ff ? busy_cnt_ff + 1 : 0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  hold_tx_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte moved");
  reset_ack_a: assert property (rx_valid && rx_data == 8'hFF
    && !powered_down_ff |-> ##2 tx_valid && tx_data == 8'hFA)
    else $error("no ack after reset command");
  page_clear_a: assert property (rx_valid && rx_data == 8'hFF
    && !powered_down_ff |-> ##2 reg_page_ff == 8'h00 && !reporting_on)
    else $error("page or reporting not cleared");
  motion_clear_a: assert property (rx_valid && rx_data == 8'hF6
    && !powered_down_ff |-> ##[1:2] clear_motion_ff)
    else $error("motion not cleared on defaults");
  disable_stop_a: assert property (rx_valid && rx_data == 8'hF5
    && !powered_down_ff |-> ##2 !reporting_on)
    else $error("reporting still on after disable");
  type_reply_a: assert property (rx_valid && rx_data == 8'hF2
    && !powered_down_ff |-> ##2 tx_valid && tx_data == 8'hFA)
    else $error("no ack after device type");
  down_sticky_a: assert property (powered_down_ff |=>
    powered_down_ff) else $error("power down left without reset");
  down_silent_a: assert property (powered_down_ff |->
    !tx_valid) else $error("reply while powered down");
  calib_bound_a: assert property (busy_cnt_ff <= CALIB_CYCLES + 2)
    else $error("calibration runs too long");
  write_pulse_a: assert property (reg_we_ff |=> !reg_we_ff)
    else $error("register write strobe too long");

  // Main scenarios reached
  cover property (rx_valid && rx_data == 8'hFF);
  cover property ($fell(calib_busy_ff));
  cover property (reg_we_ff);
  cover property ($rose(powered_down_ff));
endmodule

bind mouse_cmd_handler mouse_cmd_props #(.CALIB_CYCLES(CALIB_CYCLES))
  i_mouse_cmd_props (.ref_clk, .rst_b, .rx_valid, .rx_data, .tx_valid,
  .tx_data, .tx_ready, .clear_motion_ff, .calib_busy_ff, .powered_down_ff,
  .reporting_on, .reg_we_ff, .reg_page_ff);

// ---- tb/host_port_model.sv ----
// Host port model: takes reply bytes, at full rate or throttled
`timescale 1ns/10ps
module host_port_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Reply byte stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Pacing
  input  wire logic       slow
);
  logic [7:0] got[$];
  logic [1:0] pace_ff;
  // ==========================================================
  // Byte acceptance, in order, one per valid and ready edge
  // Slow pacing keeps bytes waiting so the hold rule is exercised
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pace_ff  <= 2'h0;
      tx_ready <= 1'b0;
      got.delete();
    end else begin
      pace_ff  <= pace_ff + 2'h1;
      tx_ready <= !slow || (pace_ff == 2'h3);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the mouse command interpreter
`timescale 1ns/10ps
module tb_top;
  localparam CAL = 20;
  logic       ref_clk, rst_b, rx_valid, tx_valid, tx_ready, slow;
  logic [7:0] rx_data, tx_data, reg_addr_ff, reg_wdata_ff, reg_page_ff;
  logic [2:0] buttons;
  logic [8:0] move_x, move_y;
  logic       motion_event, clear_motion_ff, calib_busy_ff;
  logic       powered_down_ff, reporting_on, reg_we_ff;
  logic [7:0] regs[256];
  logic [7:0] seq[$];
  int         errors, tests_run, n;

  // ==========================================================
  // Design, host model and a small register file
  mouse_cmd_handler #(.VERSION_NUM(8'h21), .REVISION_NUM(8'h07),
    .SEC_ID(16'h5A3C), .CALIB_CYCLES(CAL)) i_mouse_cmd_handler (
    .ref_clk, .rst_b, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
    .buttons, .move_x, .move_y, .motion_event, .clear_motion_ff,
    .calib_busy_ff, .powered_down_ff, .reporting_on, .reg_we_ff,
    .reg_addr_ff, .reg_wdata_ff, .reg_page_ff, .reg_rdata(regs[reg_addr_ff]));
  host_port_model i_host_port_model (.ref_clk, .rst_b, .tx_valid, .tx_data,
    .tx_ready, .slow);
  always @(posedge ref_clk) begin
    if (reg_we_ff) regs[reg_addr_ff] <= reg_wdata_ff;
  end

  // ==========================================================
  // Clock, verdict and comparison
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ==========================================================
  // Host byte traffic; waits are bounded so a hang ends the run
  task automatic send(input logic [7:0] b);
    n = 0;
    repeat (4) @(negedge ref_clk);
    while (tx_valid !== 1'b0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      print_verdict();
    end
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
  endtask
  task automatic get(input logic [7:0] e);
    n = 0;
    while (i_host_port_model.got.size() == 0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      print_verdict();
    end
    cmp(i_host_port_model.got.pop_front(), e);
  endtask
  // Sends one byte, then expects the listed replies and nothing more
  task automatic cmd(input logic [7:0] c, input logic [7:0] r[$]);
    send(c);
    foreach (r[i]) get(r[i]);
    repeat (16) @(negedge ref_clk);
    cmp(8'(i_host_port_model.got.size()), 8'h00);
  endtask
  // Sends a run of bytes whose replies are collected later
  task automatic sends(input logic [7:0] s[$]);
    foreach (s[i]) send(s[i]);
  endtask
  task automatic hw_reset;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0; rx_valid = 1'b0; rx_data = 8'h00; slow = 1'b0;
    buttons = 3'b001; move_x = 9'h1F0; move_y = 9'h005;
    motion_event = 1'b0; errors = 0; tests_run = 0;
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'hA5;
    hw_reset();
    cmd(8'hFF, '{8'hFA, 8'hAA, 8'h00});
    cmp(reg_page_ff, 8'h00);
    cmd(8'hF2, '{8'hFA, 8'h00});
    cmd(8'hE1, '{8'hFA, 8'h3C, 8'h5A});
    cmd(8'hE9, '{8'hFA, 8'h04, 8'h02, 8'h64});
    cmd(8'hF3, '{8'hFA});
    cmd(8'hC8, '{8'hFA});
    cmd(8'hF0, '{8'hFA});
    cmd(8'hF4, '{8'hFA});
    cmp({7'h0, reporting_on}, 8'h00);
    cmd(8'hE9, '{8'hFA, 8'h64, 8'h02, 8'hC8});
    cmd(8'hEB, '{8'hFA, 8'h19, 8'hF0, 8'h05});
    cmd(8'hFE, '{8'h19, 8'hF0, 8'h05});
    cmd(8'hF5, '{8'hFA});
    cmd(8'hFE, '{8'hFA});
    cmd(8'h00, '{8'hFE});
    cmd(8'h00, '{8'hFC});
    // Throttled host: replies must wait unchanged
    slow = 1'b1;
    seq = '{8'hE8, 8'h03, 8'hE7, 8'hE6, 8'hEC};
    foreach (seq[i]) cmd(seq[i], '{8'hFA});
    slow = 1'b0;
    cmd(8'hEE, '{8'hFA});
    cmd(8'h12, '{8'h12});
    cmd(8'hF4, '{8'hF4});
    cmd(8'hEC, '{8'hFA});
    cmd(8'hE9, '{8'hFA, 8'h44, 8'h03, 8'hC8});
    cmd(8'hEA, '{8'hFA});
    cmd(8'hF4, '{8'hFA});
    cmp({7'h0, reporting_on}, 8'h01);
    @(posedge ref_clk) motion_event <= 1'b1;
    @(posedge ref_clk) motion_event <= 1'b0;
    get(8'h19);
    get(8'hF0);
    get(8'h05);
    cmd(8'hF5, '{8'hFA});
    cmd(8'hE2, '{8'hFA});
    cmd(8'h46, '{8'hFA, 8'h21, 8'h07});
    sends('{8'hE2, 8'h84});
    cmd(8'h05, '{8'hFA, 8'hFA});
    send(8'hE2);
    cmd(8'h83, '{8'hFA, 8'hFA, 8'h05});
    cmd(8'hF6, '{8'hFA});
    send(8'hE2);
    cmd(8'h83, '{8'hFA, 8'hFA, 8'h00});
    sends('{8'hE2, 8'h81, 8'h10});
    cmd(8'h3C, '{8'hFA, 8'hFA});
    sends('{8'hE2, 8'h80});
    cmd(8'h10, '{8'hFA, 8'hFA, 8'h3C});
    sends('{8'hE2, 8'h47, 8'h10});
    cmd(8'h0F, '{8'hFA, 8'hFA});
    send(8'hE2);
    cmd(8'h10, '{8'hFA, 8'hFA, 8'h33});
    sends('{8'hE2, 8'h82, 8'h20});
    get(8'hFA);
    get(8'hFA);
    for (int i = 0; i < 6; i++) get(8'(8'h20 + i) ^ 8'hA5);
    send(8'hE2);
    send(8'h51);
    get(8'hFA);
    get(8'hFA);
    // Busy must last the set calibration length
    n = 0;
    for (int k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      if (calib_busy_ff === 1'b1) n++;
    end
    cmp(8'(n >= CAL - 1 && n <= CAL + 2), 8'h01);
    send(8'hE2);
    cmd(8'h7F, '{8'hFA, 8'hFA, 8'hAA, 8'h00});
    send(8'hE2);
    cmd(8'h44, '{8'hFA});
    cmp({7'h0, powered_down_ff}, 8'h01);
    cmd(8'hF2, '{});
    hw_reset();
    cmp({7'h0, powered_down_ff}, 8'h00);
    cmd(8'hF2, '{8'hFA, 8'h00});
    print_verdict();
  end
endmodule
